/* hdlc_txrx_pkg.sv */
// Overview of operation
// - Transmit FIFO empty flag follows FIFO occupancy live, high when no bytes held.
// - Transmit FIFO full flag follows FIFO occupancy live, high when no room left.
// - Underrun flag sets when FIFO runs dry before end-of-message was given.
// - An underrun sends an abort toward the bit-level transmitter automatically.
// - Underrun flag stays latched until the host reads the transmit info register.
// - Upper five bits of the transmit info register are unassigned; host ignores them.
// - Each write to the FIFO port loads one byte unless the FIFO is full, bit seven as MSB.
// - Source select zero feeds receiver from Sa bits enabled by control-two bits.
// - Source select one feeds receiver per the routing register's remaining fields.
// - Sa routing: select bits four..zero enable Sa4..Sa8 respectively.
// - Channel routing feeds DS0 data; channel mode bit picks how channels are chosen.
// - Channel mode zero: select bits name the single DS0 channel used.
// - Channel number uses select bit four as MSB, bit zero as LSB.
// - DS0 bit positions whose suppress bit is one are dropped; bit seven is MSB.
package hdlc_txrx_pkg;

  // Register offsets on the parallel control port
  localparam logic [7:0] tx_hdlc_info_addr = 8'hb6;
  localparam logic [7:0] tx_hdlc_fifo_port_addr = 8'hb7;
  localparam logic [7:0] rx_hdlc_routing_ctl_addr = 8'hb8;
  localparam logic [7:0] rx_bit_suppress_reg_addr = 8'hb9;

  // Reset values
  localparam logic [7:0] routing_reset = 8'h00;
  localparam logic [7:0] suppress_reset = 8'h00;

  // Field positions of the routing control register
  localparam int rx_source_select_pos = 7;
  localparam int rx_spare_or_channel_select_pos = 6;
  localparam int rx_channel_mode_pos = 5;

  // Field positions of the transmit info register
  localparam int tx_fifo_empty_pos = 2;
  localparam int tx_fifo_full_pos = 1;
  localparam int tx_underrun_pos = 0;

  // Sa bit numbering
  localparam logic [3:0] sa_first = 4'h4;
  localparam logic [3:0] sa_last = 4'h8;

  // Host request on the parallel control port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  // One received bit from the framer with its position in the frame
  typedef struct packed {
    logic strobe;
    logic data;
    logic [4:0] timeslot;
    logic [2:0] bit_pos;
    logic sa_flag;
    logic [3:0] sa_index;
  } rx_slot_t;

  // Transmit byte toward the bit-level transmitter
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } tx_byte_t;

  // Status seen by the host
  typedef struct packed {
    logic empty;
    logic full;
    logic underrun;
  } tx_status_t;

endpackage : hdlc_txrx_pkg

/* byte_fifo.sv */
module byte_fifo
  import hdlc_txrx_pkg::*;
#(
  parameter int width = 8,
  parameter int depth = 8
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);

  localparam int aw = $clog2(depth);

  typedef struct packed {
    logic [depth-1:0][width-1:0] mem;
    logic [aw-1:0] wr_ptr;
    logic [aw-1:0] rd_ptr;
    logic [aw:0] count;
    logic [width-1:0] head;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic push;
  logic pop;
  logic [aw-1:0] nrd;

  assign in_ready = (st.count != (aw+1)'(depth));
  assign out_valid = (st.count != '0);
  assign out_data = st.head;

  // Pointer, count and head-register update
  always_comb
  begin
    next_st = st;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    nrd = st.rd_ptr;
    if (push)
    begin
      next_st.mem[st.wr_ptr] = in_data;
      next_st.wr_ptr = (st.wr_ptr == aw'(depth - 1)) ? '0 : st.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      nrd = (st.rd_ptr == aw'(depth - 1)) ? '0 : st.rd_ptr + 1'b1;
    end
    next_st.rd_ptr = nrd;
    next_st.count = st.count + (aw+1)'(push) - (aw+1)'(pop);
    // Bypass so a byte written into the head slot is visible at once
    next_st.head = (push && nrd == st.wr_ptr) ? in_data : st.mem[nrd];
  end

  // State register
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

endmodule : byte_fifo

/* hdlc_tx_fifo_rx_route.sv */
module hdlc_tx_fifo_rx_route
  import hdlc_txrx_pkg::*;
#(
  parameter int fifo_depth = 8
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // Parallel control port
  input wire host_req_t host_req,
  output logic [7:0] host_rdata,
  // Controls held in registers outside this block
  input wire logic tx_end_of_message_ctl,
  input wire logic [4:0] rx_control_two,
  input wire logic [31:0] rx_chan_block_en,
  // Transmit byte stream toward the bit-level transmitter
  output tx_byte_t tx_byte,
  input wire logic tx_byte_ready,
  output logic tx_abort,
  output logic tx_msg_done,
  // Live status copies
  output tx_status_t tx_status,
  // Receive routing
  input wire rx_slot_t rx_slot,
  output logic hdlc_rx_strobe,
  output logic hdlc_rx_data
);

  // Block state
  typedef struct packed {
    logic [7:0] routing;
    logic [7:0] suppress;
    logic underrun;
    logic msg_active;
    logic eom_seen;
    tx_byte_t out;
    logic abort;
    logic msg_done;
    logic [7:0] rdata;
    tx_status_t status;
    logic rx_strobe;
    logic rx_data;
  } route_state_t;

  route_state_t st;
  route_state_t next_st;

  // FIFO hookup
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;

  // Decode helpers
  logic wr_fifo_port;
  logic wr_routing;
  logic wr_suppress;
  logic rd_info;
  logic out_slot_free;
  logic underrun_event;
  logic clean_end;
  logic route_hit;
  logic [2:0] suppress_idx;
  logic [31:0] chan_sel;
  logic msg_dry;
  logic eom_now;

  // Register access decode, used for every offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction : hit

  // Sa enable lookup: enable bit four is Sa4 down to bit zero for Sa8
  function automatic logic sa_enabled(input logic [4:0] en, input logic [3:0] sa);
    logic [3:0] idx;
    idx = sa_last - sa;
    if (sa >= sa_first && sa <= sa_last)
      sa_enabled = en[idx[2:0]];
    else
      sa_enabled = 1'b0;
  endfunction : sa_enabled

  // Write strobes for the FIFO port, routing and suppress registers; read strobe for the info register
  assign wr_fifo_port = host_req.wr && hit(host_req.addr, tx_hdlc_fifo_port_addr);
  assign wr_routing = host_req.wr && hit(host_req.addr, rx_hdlc_routing_ctl_addr);
  assign wr_suppress = host_req.wr && hit(host_req.addr, rx_bit_suppress_reg_addr);
  assign rd_info = host_req.rd && hit(host_req.addr, tx_hdlc_info_addr);

  // A write into a full FIFO is dropped; the host watches the full flag
  assign fifo_in_valid = wr_fifo_port;

  // Output stage takes a new byte once it is empty or being consumed
  assign out_slot_free = !st.out.valid || tx_byte_ready;
  assign fifo_out_ready = out_slot_free;

  // Message runs dry once the stage wants a byte and the FIFO has none
  assign msg_dry = st.msg_active && out_slot_free && !fifo_out_valid;

  // End-of-message either remembered earlier or raised right now
  assign eom_now = st.eom_seen || tx_end_of_message_ctl;

  // Dry with end-of-message closes cleanly, dry without it is an underrun
  assign clean_end = msg_dry && eom_now;
  assign underrun_event = msg_dry && !eom_now;

  // Suppress bit seven covers the first, most significant bit of the slot
  assign suppress_idx = 3'h7 - rx_slot.bit_pos;

  // Per-timeslot channel match: single numbered channel or block enables
  for (genvar ts = 0; ts < 32; ts++)
  begin : g_chan_sel
    assign chan_sel[ts] = st.routing[rx_channel_mode_pos]
                          ? rx_chan_block_en[ts]
                          : (st.routing[4:0] == 5'(ts));
  end

  // Receive source selection
  always_comb
  begin
    route_hit = 1'b0;
    if (!st.routing[rx_source_select_pos])
    begin
      // Sa bits chosen by the receive control two enables
      route_hit = rx_slot.sa_flag && sa_enabled(rx_control_two, rx_slot.sa_index);
    end
    else if (!st.routing[rx_spare_or_channel_select_pos])
    begin
      // Sa bits chosen by the select field
      route_hit = rx_slot.sa_flag
                  && sa_enabled(st.routing[4:0], rx_slot.sa_index);
    end
    else
    begin
      // DS0 channel data, minus Sa bits and suppressed bit positions
      route_hit = chan_sel[rx_slot.timeslot];
      route_hit = route_hit && !rx_slot.sa_flag;
      route_hit = route_hit && !st.suppress[suppress_idx];
    end
  end

  // Next-state logic for the whole block
  always_comb
  begin
    next_st = st;

    // Control register writes
    if (wr_routing)
    begin
      next_st.routing = host_req.wdata;
    end
    if (wr_suppress)
    begin
      next_st.suppress = host_req.wdata;
    end

    // Read data; unassigned bits of the info register read zero
    if (host_req.rd)
    begin
      next_st.rdata = 8'h00;
      if (rd_info)
      begin
        next_st.rdata[tx_fifo_empty_pos] = !fifo_out_valid;
        next_st.rdata[tx_fifo_full_pos] = !fifo_in_ready;
        next_st.rdata[tx_underrun_pos] = st.underrun;
      end
      else if (hit(host_req.addr, rx_hdlc_routing_ctl_addr))
      begin
        next_st.rdata = st.routing;
      end
      else if (hit(host_req.addr, rx_bit_suppress_reg_addr))
      begin
        next_st.rdata = st.suppress;
      end
    end

    // Underrun flag: latched, cleared by a read, a new event wins the clear
    if (rd_info)
    begin
      next_st.underrun = 1'b0;
    end
    if (underrun_event)
    begin
      next_st.underrun = 1'b1;
    end

    // End-of-message request held until the message closes
    if (tx_end_of_message_ctl && st.msg_active)
    begin
      next_st.eom_seen = 1'b1;
    end

    // Output stage toward the bit-level transmitter
    if (out_slot_free)
    begin
      next_st.out.valid = fifo_out_valid;
      if (fifo_out_valid)
      begin
        next_st.out.data = fifo_out_data;
        next_st.msg_active = 1'b1;
      end
    end

    // Abort and message-done pulses
    next_st.abort = underrun_event;
    next_st.msg_done = clean_end;

    // Either ending closes the message and forgets end-of-message
    if (underrun_event || clean_end)
    begin
      next_st.msg_active = 1'b0;
      next_st.eom_seen = 1'b0;
    end

    // Live status copies
    next_st.status.empty = !fifo_out_valid;
    next_st.status.full = !fifo_in_ready;
    next_st.status.underrun = next_st.underrun;

    // Routed receive bit
    next_st.rx_strobe = rx_slot.strobe && route_hit;
    next_st.rx_data = rx_slot.data;
  end

  // State register; clock enable freezes everything
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '0;
      st.routing <= routing_reset;
      st.suppress <= suppress_reset;
      st.status.empty <= 1'b1;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  // Transmit FIFO
  byte_fifo #(
    .width(8),
    .depth(fifo_depth)
  ) u_tx_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(host_req.wdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Outputs straight from flops
  assign host_rdata = st.rdata;
  assign tx_byte = st.out;
  assign tx_abort = st.abort;
  assign tx_msg_done = st.msg_done;
  assign tx_status = st.status;
  assign hdlc_rx_strobe = st.rx_strobe;
  assign hdlc_rx_data = st.rx_data;

endmodule : hdlc_tx_fifo_rx_route

/* hdlc_route_sva.sv */
module hdlc_route_chk
  import hdlc_txrx_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire host_req_t host_req,
  input wire logic [7:0] host_rdata,
  input wire logic [4:0] rx_control_two,
  input wire tx_byte_t tx_byte,
  input wire logic tx_byte_ready,
  input wire logic tx_abort,
  input wire logic tx_msg_done,
  input wire tx_status_t tx_status,
  input wire rx_slot_t rx_slot,
  input wire logic hdlc_rx_strobe,
  input wire logic hdlc_rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rt;
  logic [7:0] sp;
  logic rd6;
  logic hit0;
  logic hit1;
  // Shadow of routing and suppress registers
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      rt <= 8'h00;
      sp <= 8'h00;
    end
    else if (ce && host_req.wr)
    begin
      if (host_req.addr == 8'hb8) rt <= host_req.wdata;
      if (host_req.addr == 8'hb9) sp <= host_req.wdata;
    end
  // Info read and routed slot conditions
  assign rd6 = ce && host_req.rd && host_req.addr == 8'hb6;
  assign hit0 = ce && rx_slot.strobe && !rt[7] && rx_slot.sa_flag
    && rx_control_two[8 - rx_slot.sa_index];
  assign hit1 = ce && rx_slot.strobe && rt[7:5] == 3'b110 && !rx_slot.sa_flag
    && rx_slot.timeslot == rt[4:0] && !sp[7 - rx_slot.bit_pos];
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_pad; rd6 |=> host_rdata[7:3] == 5'h00; endproperty
  a_pad: assert property (p_pad) else $error("info pad bits set");
  property p_abort; tx_abort |-> ##[0:1] tx_status.underrun; endproperty
  a_abort: assert property (p_abort) else $error("abort without flag");
  property p_latch; tx_status.underrun && !rd6 && !$past(rd6) |=> tx_status.underrun; endproperty
  a_latch: assert property (p_latch) else $error("underrun lost");
  property p_clear; rd6 ##1 (ce && !tx_abort) [*3] |-> !tx_status.underrun; endproperty
  a_clear: assert property (p_clear) else $error("underrun not cleared");
  property p_hold; tx_byte.valid && !tx_byte_ready |=> tx_byte.valid && $stable(tx_byte.data);
  endproperty
  a_hold: assert property (p_hold) else $error("byte not held");
  property p_cause;
    hdlc_rx_strobe |-> $past(rx_slot.strobe && ce) && hdlc_rx_data == $past(rx_slot.data);
  endproperty
  a_cause: assert property (p_cause) else $error("stray rx bit");
  property p_sa; hit0 |=> hdlc_rx_strobe; endproperty
  a_sa: assert property (p_sa) else $error("sa bit not routed");
  property p_chan; hit1 |=> hdlc_rx_strobe; endproperty
  a_chan: assert property (p_chan) else $error("channel bit not routed");
  c_abort: cover property (tx_abort);
  c_done: cover property (tx_msg_done);
  c_full: cover property (tx_status.full);
endmodule : hdlc_route_chk

bind hdlc_tx_fifo_rx_route hdlc_route_chk hdlc_route_chk_inst (.mclk, .reset_n, .ce,
  .host_req, .host_rdata, .rx_control_two, .tx_byte, .tx_byte_ready, .tx_abort,
  .tx_msg_done, .tx_status, .rx_slot, .hdlc_rx_strobe, .hdlc_rx_data);

/* tx_sink.sv */
module tx_sink
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic stall,
  output logic tx_byte_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Accepts bytes unless told to stall
  always @(posedge mclk or negedge reset_n)
    if (!reset_n) tx_byte_ready <= 1'b0;
    else tx_byte_ready <= !stall;
endmodule : tx_sink

/* tb.sv */
module tb;
  import hdlc_txrx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, reset_n = 0, ce = 1, eom = 0, stall = 0;
  host_req_t host_req = '0;
  logic [4:0] c2 = '0;
  logic [31:0] be = '0;
  rx_slot_t rx_slot = '0;
  logic [7:0] host_rdata, rt, sp, d;
  tx_byte_t tx_byte;
  tx_status_t st;
  rx_slot_t s;
  logic rdy, abort, done, hs, hd, rdp = 0;
  int num_errors = 0, checks = 0, seed = 89852, aborts = 0, dones = 0;
  logic [7:0] rq[$], bq[$];
  logic xq[$];

  hdlc_tx_fifo_rx_route #(.fifo_depth(8)) hdlc_tx_fifo_rx_route_inst (.mclk(mclk),
    .reset_n(reset_n), .ce(ce), .host_req(host_req), .host_rdata(host_rdata),
    .tx_end_of_message_ctl(eom), .rx_control_two(c2), .rx_chan_block_en(be),
    .tx_byte(tx_byte), .tx_byte_ready(rdy), .tx_abort(abort), .tx_msg_done(done),
    .tx_status(st), .rx_slot(rx_slot), .hdlc_rx_strobe(hs), .hdlc_rx_data(hd));
  tx_sink tx_sink_inst (.mclk(mclk), .reset_n(reset_n), .stall(stall), .tx_byte_ready(rdy));

  initial forever #12.5 mclk = ~mclk;

  task check(input string n, input logic [31:0] v, input logic [31:0] e);
    checks++;
    if (v !== e)
    begin
      num_errors++;
      $display("mismatch %s exp %h seen %h", n, e, v);
    end
  endtask : check

  task conclude();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // One strobed access, then idle
  task bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    host_req <= '{wr: w, rd: !w, addr: a, wdata: v};
    @(posedge mclk);
    host_req <= '0;
  endtask : bus

  task rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    bus(0, a, 8'h00);
  endtask : rd

  // Expected routing of one slot
  function logic hit(input rx_slot_t x);
    if (!rt[7]) return x.sa_flag && c2[8 - x.sa_index];
    if (!rt[6]) return x.sa_flag && rt[8 - x.sa_index];
    return !x.sa_flag && (rt[5] ? be[x.timeslot] : x.timeslot == rt[4:0])
      && !sp[7 - x.bit_pos];
  endfunction : hit

  task slot();
    s = 15'($random(seed));
    s.strobe = 1;
    s.sa_index = 4'(4 + ($random(seed) & 7) % 5);
    if ($random(seed) & 1) s.timeslot = rt[4:0];
    if (hit(s)) xq.push_back(s.data);
    @(posedge mclk);
    rx_slot <= s;
    @(posedge mclk);
    rx_slot <= '0;
  endtask : slot

  // Output watcher against noted expectations
  always @(posedge mclk)
  begin
    if (rdp) check("rdata", host_rdata, rq.pop_front());
    rdp = ce && host_req.rd;
    if (tx_byte.valid && rdy) check("byte", tx_byte.data, bq.pop_front());
    if (hs) check("rxbit", hd, xq.size() ? xq.pop_front() : 1'bx);
    if (abort) aborts++;
    if (done) dones++;
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    conclude();
  end

  initial
  begin
    repeat (12) @(posedge mclk);
    reset_n <= 1;
    // Reset values, read-only and unmapped places
    rd(8'hb6, 8'h04);
    check("status", st, 3'b100);
    rd(8'hb8, 8'h00);
    rd(8'hb9, 8'h00);
    bus(1, 8'hb6, 8'hff);
    rd(8'hc0, 8'h00);
    rd(8'hb6, 8'h04);
    // Lone byte without end-of-message runs dry
    d = 8'($random(seed));
    bq.push_back(d);
    bus(1, 8'hb7, d);
    repeat (8) @(posedge mclk);
    check("status", st, 3'b101);
    rd(8'hb6, 8'h05);
    rd(8'hb6, 8'h04);
    check("aborts", aborts, 1);
    // Stalled sink: fill until a byte is refused, then drain with end-of-message
    stall <= 1;
    eom <= 1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 10; i++)
    begin
      d = 8'($random(seed));
      if (i < 9) bq.push_back(d);
      bus(1, 8'hb7, d);
    end
    rd(8'hb6, 8'h02);
    check("status", st, 3'b010);
    stall <= 0;
    repeat (40) @(posedge mclk);
    rd(8'hb6, 8'h04);
    check("aborts", aborts, 1);
    check("dones", dones, 1);
    eom <= 0;
    // Clock enable low ignores a write
    ce <= 0;
    bus(1, 8'hb8, 8'hff);
    ce <= 1;
    rd(8'hb8, 8'h00);
    // Random routing setups with random slots
    repeat (40)
    begin
      c2 <= 5'($random(seed));
      be <= $random(seed);
      rt = 8'($random(seed));
      sp = 8'($random(seed));
      bus(1, 8'hb8, rt);
      bus(1, 8'hb9, sp);
      rd(8'hb8, rt);
      rd(8'hb9, sp);
      repeat (8) slot();
    end
    repeat (4) @(posedge mclk);
    check("left", rq.size() + bq.size() + xq.size(), 0);
    conclude();
  end
endmodule : tb
